// file: rtl/iohx_monitor.sv
/*
  I/O status monitor: samples the terminal pins, packs them into a
  status word, drives a four-digit seven-segment monitor in hex or
  per-segment form, and runs the front-panel menu mode for entry to
  the maintenance menu. Software reaches control and status over
  Avalon-MM with waitrequest.
  Assumes pins and keys are asynchronous to mclk; keys arrive clean
  (debounced) and active high.
  Hex view: nibble k drives digit k+1, so the top nibble lands on the
  leftmost digit; the decimal point stays dark.
  Per-segment base view: digit 1 holds the run and general inputs,
  digit 2 the communicated commands, digit 3 the transistor outputs
  and digit 4 the relay contact; the option view has no dash rule.
  Limits: a read holds waitrequest for one cycle, so each read takes
  two cycles, back to back included; writes to any address
  but control are ignored and never wait. Pin changes reach the
  status word one cycle after sampling, the digits one cycle later.
  A change of menu range away from full drops maintenance at once.
*/
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
// Notes on behaviour
// - each terminal is one bit of a 16-bit word; unassigned bits are zero
// - word shown as four hex digits, top nibble on leftmost digit
// - forward run bit 0, reverse run bit 1, general inputs bits 2 to 6
// - input bit is one when the terminal is closed
// - transistor outputs on bits 0 and 1, one when conducting
// - relay contact state on bit 8, one when closed
// - under comms control, commands forward 13, reverse 14, reset 15
// - communicated commands shown in original, non-inverted polarity
// - comms word available in both per-segment and hex forms
// - option inputs bits 0-11, selector 12, outputs bits 0-7
// - option per-segment: digit1 inputs 1-8, digit2 9-12 and selector, digit3 outputs
// - maintenance menu reachable only when menu range setting is 2
// - power-on enters running mode; enter key opens function menu
// - all base inputs, outputs and relay (and commands under comms) off in per-segment form lights middle bar on all digits
`timescale 1ns/1ps
module iohx_monitor #(
  parameter int MENU_ITEMS = 8
) (
  input  wire logic                 mclk,
  input  wire logic                 arst_n,
  // Avalon-MM slave
  input  wire logic [iohx_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  // terminal pins
  input  wire iohx_pkg::iohx_base_t base_pins,
  input  wire iohx_pkg::iohx_comm_t comm_pins,
  input  wire iohx_pkg::iohx_opt_t  opt_pins,
  input  wire iohx_pkg::iohx_keys_t key_pins,
  // display
  output logic [4*8-1:0]            digit_seg,
  output iohx_pkg::iohx_mode_t      panel_mode,
  output logic [7:0]                menu_index
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_s1_r;
  logic rst_n_r;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int PIN_W = $bits(iohx_pkg::iohx_base_t) + $bits(iohx_pkg::iohx_comm_t)
                       + $bits(iohx_pkg::iohx_opt_t) + $bits(iohx_pkg::iohx_keys_t);
  logic [PIN_W-1:0] pin_s1_r;
  logic [PIN_W-1:0] pin_s2_r;
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= {base_pins, comm_pins, opt_pins, key_pins};
      pin_s2_r <= pin_s1_r;
    end
  end

  iohx_pkg::iohx_base_t base_s;
  iohx_pkg::iohx_comm_t comm_s;
  iohx_pkg::iohx_opt_t  opt_s;
  iohx_pkg::iohx_keys_t keys_s;
  assign {base_s, comm_s, opt_s, keys_s} = pin_s2_r;

  // ---------------------------------------------------------------
  // key edge detect on the synchronised copy
  // ---------------------------------------------------------------
  iohx_pkg::iohx_keys_t keys_d_r;
  iohx_pkg::iohx_keys_t key_evt;
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      keys_d_r <= '0;
    end else begin
      keys_d_r <= keys_s;
    end
  end
  assign key_evt = keys_s & ~keys_d_r;

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic        rd_done_r;
  logic        wr_en;
  iohx_pkg::iohx_src_t src;
  logic        seg_mode;
  logic        out_sel;
  logic [1:0]  menu_range;
  logic        rd_take;

  // ---------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------
  assign wr_en      = avs_write && avs_address == iohx_pkg::OFS_CTRL;
  assign src        = iohx_pkg::iohx_src_t'(ctrl_r[iohx_pkg::CTRL_SRC_LSB +: 2]);
  assign seg_mode   = ctrl_r[iohx_pkg::CTRL_SEGMODE];
  assign out_sel    = ctrl_r[iohx_pkg::CTRL_OUTSEL];
  assign menu_range = ctrl_r[iohx_pkg::CTRL_RANGE_LSB +: 2];

  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r <= iohx_pkg::CTRL_RESET;
    end else if (wr_en) begin
      ctrl_r <= {26'h0, avs_writedata[5:0]};
    end
  end

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  // writes complete at once; reads take one wait cycle
  // first cycle of a read: capture data, release the wait next edge
  assign rd_take         = avs_read && !rd_done_r;
  assign avs_waitrequest = rd_take;

  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rd_done_r <= 1'b0;
    end else begin
      rd_done_r <= rd_take;
    end
  end

  // ---------------------------------------------------------------
  // status word and display
  // ---------------------------------------------------------------
  logic [15:0] word;
  logic [31:0] hex_seg;
  logic [31:0] disp_nxt;
  logic [31:0] disp_r;

  iohx_word_pack u_pack (
    .src     (src),
    .out_sel (out_sel),
    .base    (base_s),
    .comm    (comm_s),
    .opt     (opt_s),
    .word    (word)
  );

  // ---------------------------------------------------------------
  // hex glyphs
  // ---------------------------------------------------------------
  // digit k (k=0 rightmost) shows nibble k
  genvar gi;
  generate
    for (gi = 0; gi < iohx_pkg::DIGITS; gi++) begin : g_dig
      iohx_hex_seg u_seg (
        .nibble (word[gi*4 +: 4]),
        .seg    (hex_seg[gi*8 +: 8])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // display select
  // ---------------------------------------------------------------
  // per-segment form; bytes are digits 1..4, bits {dp,g,f,e,d,c,b,a}
  always_comb begin
    disp_nxt = hex_seg;
    if (seg_mode) begin
      disp_nxt = 32'h0000_0000;
      if (src == iohx_pkg::SRC_OPT) begin
        disp_nxt[7:0]   = opt_s.option_input[7:0];
        disp_nxt[11:8]  = opt_s.option_input[11:8];
        disp_nxt[12]    = opt_s.option_selector;
        disp_nxt[23:16] = opt_s.option_output;
      end else begin
        // digit 1 run and general inputs
        disp_nxt[0]     = base_s.forward_run_input;
        disp_nxt[1]     = base_s.reverse_run_input;
        disp_nxt[6:2]   = base_s.general_input;
        // digit 3 transistor outputs, digit 4 relay
        disp_nxt[17:16] = base_s.transistor_output;
        disp_nxt[24]    = base_s.relay_contact_output;
        if (src == iohx_pkg::SRC_COMM) begin
          disp_nxt[13] = comm_s.comm_forward_command;
          disp_nxt[14] = comm_s.comm_reverse_command;
          disp_nxt[15] = comm_s.comm_reset_command;
        end
        if (disp_nxt == 32'h0000_0000) begin
          disp_nxt = {4{iohx_pkg::SEG_DASH}};
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      disp_r <= {4{iohx_pkg::SEG_OFF}};
    end else begin
      disp_r <= disp_nxt;
    end
  end
  assign digit_seg = disp_r;

  // ---------------------------------------------------------------
  // front panel menu
  // ---------------------------------------------------------------
  // function menu slot of the maintenance menu
  localparam logic [7:0] MAINT_IDX = 8'h05;
  iohx_pkg::iohx_mode_t mode_r;
  logic [7:0]           idx_r;

  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mode_r <= iohx_pkg::MODE_RUN;
    end else begin
      unique case (mode_r)
        iohx_pkg::MODE_RUN: begin
          if (key_evt.enter) begin
            mode_r <= iohx_pkg::MODE_PROG;
          end
        end
        iohx_pkg::MODE_PROG: begin
          if (key_evt.escape) begin
            mode_r <= iohx_pkg::MODE_RUN;
          end else if (key_evt.enter && idx_r == MAINT_IDX
                       && menu_range == iohx_pkg::RANGE_FULL) begin
            mode_r <= iohx_pkg::MODE_MAINT;
          end
        end
        iohx_pkg::MODE_MAINT: begin
          // a range change drops maintenance at once
          if (key_evt.escape || menu_range != iohx_pkg::RANGE_FULL) begin
            mode_r <= iohx_pkg::MODE_PROG;
          end
        end
        default: mode_r <= iohx_pkg::MODE_RUN;
      endcase
    end
  end

  // menu cursor, wraps over the function menu
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      idx_r <= 8'h00;
    end else if (mode_r == iohx_pkg::MODE_PROG) begin
      if (key_evt.up) begin
        idx_r <= (idx_r == 8'(MENU_ITEMS - 1)) ? 8'h00 : idx_r + 8'h01;
      end else if (key_evt.down) begin
        idx_r <= (idx_r == 8'h00) ? 8'(MENU_ITEMS - 1) : idx_r - 8'h01;
      end
    end
  end

  assign panel_mode = mode_r;
  assign menu_index = idx_r;

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [31:0] rdata_nxt;

  // decode on the request cycle, held until the next read
  always_comb begin
    unique case (avs_address)
      iohx_pkg::OFS_CTRL: rdata_nxt = ctrl_r;
      iohx_pkg::OFS_WORD: rdata_nxt = {16'h0000, word};
      iohx_pkg::OFS_SEGS: rdata_nxt = disp_r;
      iohx_pkg::OFS_MENU: rdata_nxt = {22'h0, mode_r, idx_r};
      default:            rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_take) begin
      avs_readdata <= rdata_nxt;
    end
  end

endmodule : iohx_monitor

// file: inc/iohx_pkg.sv
/*
  Package for the I/O status monitor: register map, field positions,
  reset values, mode encodings and the packed carriers shared by the
  monitor core, the status word packer and the port checker.
  Assumes a 32-bit Avalon-MM slave port with word-aligned registers.
*/
package iohx_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_WORD   = 4'h4;
  localparam logic [3:0] OFS_SEGS   = 4'h8;
  localparam logic [3:0] OFS_MENU   = 4'hC;
  localparam int         ADDR_W     = 4;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int CTRL_SRC_LSB   = 0;   // 2-bit source select
  localparam int CTRL_SEGMODE   = 2;   // 1: per-segment form
  localparam int CTRL_OUTSEL    = 3;   // 1: output word
  localparam int CTRL_RANGE_LSB = 4;   // 2-bit menu range setting
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // menu range value that opens the full menu
  localparam logic [1:0] RANGE_FULL = 2'h2;

  // ---------------------------------------------------------------
  // status word bit positions
  // ---------------------------------------------------------------
  localparam int BIT_FORWARD  = 0;
  localparam int BIT_REVERSE  = 1;
  localparam int BIT_GEN_LSB  = 2;
  localparam int GEN_INPUTS   = 5;
  localparam int BIT_TR_LSB   = 0;
  localparam int BIT_RELAY    = 8;
  localparam int BIT_CFWD     = 13;
  localparam int BIT_CREV     = 14;
  localparam int BIT_CRST     = 15;
  localparam int OPT_INPUTS   = 12;
  localparam int BIT_OPT_SEL  = 12;
  localparam int OPT_OUTPUTS  = 8;
  localparam int DIGITS       = 4;

  // segment all-off / middle bar
  localparam logic [7:0] SEG_OFF  = 8'h00;
  localparam logic [7:0] SEG_DASH = 8'h40;

  // ---------------------------------------------------------------
  // enumerations and carriers
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_BASE = 2'h0,
    SRC_COMM = 2'h1,
    SRC_OPT  = 2'h2
  } iohx_src_t;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_PROG,
    MODE_MAINT
  } iohx_mode_t;

  // base terminal states, 1 = closed
  typedef struct packed {
    logic                  forward_run_input;
    logic                  reverse_run_input;
    logic [GEN_INPUTS-1:0] general_input;
    logic [1:0]            transistor_output;
    logic                  relay_contact_output;
  } iohx_base_t;

  // communicated commands
  typedef struct packed {
    logic comm_forward_command;
    logic comm_reverse_command;
    logic comm_reset_command;
  } iohx_comm_t;

  // option board terminals
  typedef struct packed {
    logic [OPT_INPUTS-1:0]  option_input;
    logic                   option_selector;
    logic [OPT_OUTPUTS-1:0] option_output;
  } iohx_opt_t;

  // front panel keys, held levels at the pins; one-cycle pulses after the edge detect on the synchronised copy
  typedef struct packed {
    logic enter;
    logic up;
    logic down;
    logic escape;
  } iohx_keys_t;

endpackage : iohx_pkg

// file: rtl/iohx_word_pack.sv
/*
  Packs terminal states into the 16-bit status word for the chosen
  source (base, communications, option board) and direction.
  Assumes all inputs are already synchronised to mclk.
*/
`timescale 1ns/1ps
module iohx_word_pack (
  input  wire iohx_pkg::iohx_src_t  src,
  input  wire logic                 out_sel,
  input  wire iohx_pkg::iohx_base_t base,
  input  wire iohx_pkg::iohx_comm_t comm,
  input  wire iohx_pkg::iohx_opt_t  opt,
  output logic [15:0]               word
);

  always_comb begin
    word = 16'h0000;
    if (src == iohx_pkg::SRC_OPT) begin
      if (out_sel) begin
        word[iohx_pkg::OPT_OUTPUTS-1:0] = opt.option_output;
      end else begin
        word[iohx_pkg::OPT_INPUTS-1:0] = opt.option_input;
        word[iohx_pkg::BIT_OPT_SEL]    = opt.option_selector;
      end
    end else if (out_sel) begin
      word[iohx_pkg::BIT_TR_LSB +: 2] = base.transistor_output;
      word[iohx_pkg::BIT_RELAY]       = base.relay_contact_output;
    end else begin
      word[iohx_pkg::BIT_FORWARD] = base.forward_run_input;
      word[iohx_pkg::BIT_REVERSE] = base.reverse_run_input;
      word[iohx_pkg::BIT_GEN_LSB +: iohx_pkg::GEN_INPUTS] = base.general_input;
      if (src == iohx_pkg::SRC_COMM) begin
        // raw command polarity, no terminal inversion applied
        word[iohx_pkg::BIT_CFWD] = comm.comm_forward_command;
        word[iohx_pkg::BIT_CREV] = comm.comm_reverse_command;
        word[iohx_pkg::BIT_CRST] = comm.comm_reset_command;
      end
    end
  end

endmodule : iohx_word_pack

// file: rtl/iohx_hex_seg.sv
/*
  Seven-segment glyph encoder for one hexadecimal nibble.
  Segment order in the result is {dp,g,f,e,d,c,b,a}, dp always off.
*/
`timescale 1ns/1ps
module iohx_hex_seg (
  input  wire logic [3:0] nibble,
  output logic      [7:0] seg
);

  always_comb begin
    unique case (nibble)
      4'h0:    seg = 8'h3F;
      4'h1:    seg = 8'h06;
      4'h2:    seg = 8'h5B;
      4'h3:    seg = 8'h4F;
      4'h4:    seg = 8'h66;
      4'h5:    seg = 8'h6D;
      4'h6:    seg = 8'h7D;
      4'h7:    seg = 8'h07;
      4'h8:    seg = 8'h7F;
      4'h9:    seg = 8'h6F;
      4'hA:    seg = 8'h77;
      4'hB:    seg = 8'h7C;
      4'hC:    seg = 8'h39;
      4'hD:    seg = 8'h5E;
      4'hE:    seg = 8'h79;
      4'hF:    seg = 8'h71;
    endcase
  end

endmodule : iohx_hex_seg

// file: tb/iohx_monitor_props.sv
/*
  Port-level checker for the I/O status monitor.
  Assumes a bind from the bench top and a 32-bit Avalon-MM slave.
*/
`timescale 1ns/1ps
module iohx_monitor_props #(
  parameter int MENU_ITEMS = 8
) (
  input wire logic                            mclk,
  input wire logic                            arst_n,
  input wire logic [iohx_pkg::ADDR_W-1:0]     avs_address,
  input wire logic                            avs_read,
  input wire logic                            avs_write,
  input wire logic [31:0]                     avs_writedata,
  input wire logic [31:0]                     avs_readdata,
  input wire logic                            avs_waitrequest,
  input wire iohx_pkg::iohx_keys_t            key_pins,
  input wire iohx_pkg::iohx_mode_t            panel_mode,
  input wire logic [7:0]                      menu_index
);
  logic [5:0] ctrl_r;

  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // ---------------------------------------------------------------
  // shadow of the control register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= 6'h00;
    end else if (avs_write && avs_address == iohx_pkg::OFS_CTRL) begin
      ctrl_r <= avs_writedata[5:0];
    end
  end

  // ---------------------------------------------------------------
  // bus and panel properties
  // ---------------------------------------------------------------
  write_nowait_a: assert property (avs_write |-> !avs_waitrequest)
    else $error("write was made to wait");
  idle_nowait_a: assert property (!avs_read |-> !avs_waitrequest)
    else $error("waitrequest without a read");
  read_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait is not one cycle");
  rdata_hold_a: assert property (!$stable(avs_readdata) |-> $past(avs_read && avs_waitrequest))
    else $error("read data moved outside a read");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
    |-> avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
  ctrl_back_a: assert property (avs_read && !avs_waitrequest && avs_address == 4'h0
    |-> avs_readdata == {26'h000_0000, ctrl_r}) else $error("control readback wrong");
  run_enter_a: assert property (panel_mode == iohx_pkg::MODE_RUN && $rose(key_pins.enter)
    && !key_pins.escape |-> ##[1:4] panel_mode == iohx_pkg::MODE_PROG)
    else $error("enter did not open the menu");
  maint_range_a: assert property ($rose(panel_mode == iohx_pkg::MODE_MAINT)
    |-> ctrl_r[5:4] == iohx_pkg::RANGE_FULL) else $error("maintenance without full range");
  maint_leave_a: assert property (panel_mode == iohx_pkg::MODE_MAINT
    && ctrl_r[5:4] != iohx_pkg::RANGE_FULL |-> ##[1:2] panel_mode == iohx_pkg::MODE_PROG)
    else $error("maintenance kept after range change");
  no_jump_a: assert property ($past(panel_mode) == iohx_pkg::MODE_RUN
    |-> panel_mode != iohx_pkg::MODE_MAINT) else $error("run jumped to maintenance");
  index_range_a: assert property (menu_index < 8'(MENU_ITEMS))
    else $error("menu index out of range");
endmodule : iohx_monitor_props

// file: tb/iohx_led_panel.sv
/*
  Model of the four-digit seven-segment monitor: reads glyphs back
  into the word shown. Assumes active-high {dp,g,f,e,d,c,b,a} bytes.
*/
`timescale 1ns/1ps
module iohx_led_panel (
  input wire logic [31:0] digit_seg,
  output logic     [15:0] shown_word,
  output logic            glyph_ok
);
  localparam logic [7:0] GLYPH [16] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D, 8'h7D,
    8'h07, 8'h7F, 8'h6F, 8'h77, 8'h7C, 8'h39, 8'h5E, 8'h79, 8'h71};
  logic hit;

  // digit 4 carries the top nibble
  always_comb begin
    shown_word = 16'h0000;
    glyph_ok = 1'b1;
    hit = 1'b0;
    for (int d = 0; d < 4; d++) begin
      hit = 1'b0;
      for (int n = 0; n < 16; n++) begin
        if (digit_seg[d*8 +: 8] === GLYPH[n]) begin
          shown_word[d*4 +: 4] = 4'(n);
          hit = 1'b1;
        end
      end
      if (!hit) glyph_ok = 1'b0;
    end
  end
endmodule : iohx_led_panel

// file: tb/io_status_hex_display_tb.sv
/*
  Self-checking bench for the I/O status monitor.
  Assumes the package and the design files are compiled first.
*/
`timescale 1ns/1ps
module io_status_hex_display_tb;
  localparam int MENU_N = 8;
  logic                 mclk = 1'b0;
  logic                 arst_n = 1'b0;
  logic [3:0]           avs_address = 4'h0;
  logic                 avs_read = 1'b0;
  logic                 avs_write = 1'b0;
  logic [31:0]          avs_writedata = 32'h0;
  logic [31:0]          avs_readdata;
  logic                 avs_waitrequest;
  iohx_pkg::iohx_base_t base_pins = '0;
  iohx_pkg::iohx_comm_t comm_pins = '0;
  iohx_pkg::iohx_opt_t  opt_pins = '0;
  iohx_pkg::iohx_keys_t key_pins = '0;
  logic [31:0]          digit_seg;
  iohx_pkg::iohx_mode_t panel_mode;
  logic [7:0]           menu_index;
  logic [15:0]          shown_word;
  logic                 glyph_ok;
  logic [31:0]          rd;
  logic [15:0]          ew;
  int                   err_count = 0;
  int                   n_compared = 0;

  always #50 mclk = ~mclk;

  iohx_monitor #(.MENU_ITEMS(MENU_N)) DUT (.mclk(mclk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .base_pins(base_pins), .comm_pins(comm_pins),
    .opt_pins(opt_pins), .key_pins(key_pins), .digit_seg(digit_seg),
    .panel_mode(panel_mode), .menu_index(menu_index));
  iohx_led_panel u_panel (.digit_seg(digit_seg), .shown_word(shown_word), .glyph_ok(glyph_ok));

  // ---------------------------------------------------------------
  // shared tasks and expectations
  // ---------------------------------------------------------------
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      $display("[ERR] waitrequest expected %h seen %h", 1'b0, avs_waitrequest);
      err_count++;
      wrap_up();
    end else begin
      @(posedge mclk);
    end
  endtask : bus

  function automatic logic [15:0] exp_word(input logic [3:0] c, input iohx_pkg::iohx_base_t b,
    input iohx_pkg::iohx_comm_t m, input iohx_pkg::iohx_opt_t o);
    logic [15:0] w;
    w = 16'h0000;
    if (c[1:0] == 2'h2) begin
      w = c[3] ? {8'h00, o.option_output} : {3'h0, o.option_selector, o.option_input};
    end else if (c[3]) begin
      w = {7'h00, b.relay_contact_output, 6'h00, b.transistor_output};
    end else begin
      w[6:0] = {b.general_input, b.reverse_run_input, b.forward_run_input};
      if (c[1:0] == 2'h1) w[15:13] = {m.comm_reset_command, m.comm_reverse_command,
        m.comm_forward_command};
    end
    return w;
  endfunction : exp_word

  function automatic logic [31:0] exp_seg(input logic [3:0] c, input iohx_pkg::iohx_base_t b,
    input iohx_pkg::iohx_comm_t m, input iohx_pkg::iohx_opt_t o);
    logic [31:0] s;
    if (c[1:0] == 2'h2) return {8'h00, o.option_output, 3'h0, o.option_selector,
      o.option_input};
    s = {7'h00, b.relay_contact_output, 6'h00, b.transistor_output,
      (c[1:0] == 2'h1) ? {m.comm_reset_command, m.comm_reverse_command,
      m.comm_forward_command} : 3'h0, 6'h00, b.general_input, b.reverse_run_input,
      b.forward_run_input};
    return (s == 32'h0) ? 32'h4040_4040 : s;
  endfunction : exp_seg

  task automatic view(input logic [3:0] c, input iohx_pkg::iohx_base_t b,
    input iohx_pkg::iohx_comm_t m, input iohx_pkg::iohx_opt_t o);
    bus(1'b1, 4'h0, {28'h0, c});
    base_pins <= b;
    comm_pins <= m;
    opt_pins <= o;
    repeat (5) @(posedge mclk);
    ew = exp_word(c, b, m, o);
    if (c[2]) begin
      bus(1'b0, 4'h8, 32'h0);
      chk("segments", exp_seg(c, b, m, o), rd);
    end else begin
      chk("glyphs", 32'h1, {31'h0, glyph_ok});
      chk("shown", {16'h0, ew}, {16'h0, shown_word});
    end
    bus(1'b0, 4'h4, 32'h0);
    chk("word", {16'h0, ew}, rd);
  endtask : view

  task automatic press(input logic [3:0] k);
    key_pins <= k;
    repeat (4) @(posedge mclk);
    key_pins <= '0;
    repeat (4) @(posedge mclk);
  endtask : press

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(40));
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    bus(1'b1, 4'h0, 32'hFFFF_FFFF);
    bus(1'b0, 4'h0, 32'h0);
    chk("ctrl", 32'h0000_003F, rd);
    bus(1'b0, 4'h6, 32'h0);
    chk("unmapped", 32'h0, rd);
    view(4'h4, '0, '0, '0);
    view(4'h0, 10'h208, 3'h7, '0);
    chk("input word", 32'h0005, rd);
    view(4'h8, 10'h003, '0, '0);
    chk("output word", 32'h0101, rd);
    for (int k = 0; k < 36; k++) begin
      view({2'((k / 3) % 4), 2'(k % 3)}, 10'($urandom), 3'($urandom), 21'($urandom));
    end
    press(4'h8);
    chk("to prog", 32'h1, {30'h0, panel_mode});
    press(4'h2);
    chk("index low wrap", 32'(MENU_N - 1), {24'h0, menu_index});
    press(4'h4);
    chk("index high wrap", 32'h0, {24'h0, menu_index});
    for (int k = 0; k < MENU_N && menu_index !== 8'h05; k++) press(4'h4);
    chk("index", 32'h5, {24'h0, menu_index});
    press(4'h8);
    chk("no maint", 32'h1, {30'h0, panel_mode});
    bus(1'b1, 4'h0, 32'h0000_0020);
    press(4'h8);
    chk("maint", 32'h2, {30'h0, panel_mode});
    bus(1'b0, 4'hC, 32'h0);
    chk("menu reg", 32'h0000_0205, rd);
    press(4'h1);
    chk("maint escape", 32'h1, {30'h0, panel_mode});
    press(4'h8);
    chk("maint again", 32'h2, {30'h0, panel_mode});
    bus(1'b1, 4'h0, 32'h0);
    repeat (3) @(posedge mclk);
    chk("range drop", 32'h1, {30'h0, panel_mode});
    press(4'h1);
    chk("escape", 32'h0, {30'h0, panel_mode});
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    wrap_up();
  end
endmodule : io_status_hex_display_tb

bind iohx_monitor iohx_monitor_props #(.MENU_ITEMS(MENU_ITEMS)) u_props (.mclk(mclk),
  .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .key_pins(key_pins), .panel_mode(panel_mode),
  .menu_index(menu_index));
